/* design/tlb_maint_defines.vh */
// constants shared by the translation-buffer maintenance logic
`ifndef TLB_MAINT_DEFINES_VH
`define TLB_MAINT_DEFINES_VH

// ----------------------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------------------
`define OPC_MAJOR_HI       31
`define OPC_MAJOR_LO       26
`define OPC_MAJOR_GROUP    6'h00
`define OPC_ZERO_HI        25
`define OPC_ZERO_LO        16
`define OPC_SUB_HI         15
`define OPC_SUB_LO         6
`define OPC_MINOR_HI       5
`define OPC_MINOR_LO       0
`define OPC_MINOR_GROUP    6'h3c
`define OPC_SUB_PROBE      10'h00d
`define OPC_SUB_READ       10'h04d
`define OPC_SUB_FLUSH      10'h14d

// ----------------------------------------------------------------------------
// mmu type and invalidate support encodings
// ----------------------------------------------------------------------------
`define MMU_JOINT          3'h1
`define MMU_BLOCK          3'h2
`define MMU_FIXED_MAP      3'h3
`define MMU_VAR_FIXED      3'h4
`define INV_NONE           2'h0
`define INV_SW_WALK        2'h2
`define INV_HW_WALK        2'h3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SMALLEST_PAGE_MASK 1'b0
`define TIMING_OP_CYCLES   1

`endif

/* design/tlb_op_decoder.v */
// opcode decoder for the flush, probe and read operations
`timescale 1ns/1ps
`default_nettype none
`include "tlb_maint_defines.vh"

module tlb_op_decoder (
    input  wire [31:0] instr,     // instruction word
    input  wire        instr_vld, // instruction valid
    output wire        is_flush,  // range-flush decoded
    output wire        is_probe,  // probe decoded
    output wire        is_read    // indexed read decoded
);

    // ------------------------------------------------------------------------
    // common frame check
    // ------------------------------------------------------------------------
    function sub_match;
        input [31:0] w;
        input [9:0]  sub;
        begin
            sub_match = (w[`OPC_MAJOR_HI:`OPC_MAJOR_LO] == `OPC_MAJOR_GROUP)
                     && (w[`OPC_ZERO_HI:`OPC_ZERO_LO] == 10'h000)
                     && (w[`OPC_SUB_HI:`OPC_SUB_LO] == sub)
                     && (w[`OPC_MINOR_HI:`OPC_MINOR_LO] == `OPC_MINOR_GROUP);
        end
    endfunction

    assign is_flush = instr_vld & sub_match(instr, `OPC_SUB_FLUSH);
    assign is_probe = instr_vld & sub_match(instr, `OPC_SUB_PROBE);
    assign is_read  = instr_vld & sub_match(instr, `OPC_SUB_READ);

endmodule
`default_nettype wire

/* design/tlb_maintenance_ops.v */
// translation-buffer maintenance: range flush, probe and indexed read
// Functional notes
// - range flush invalidates every entry in the pointer-selected range, ignoring address_space_id and global
// - range flush covers pinned entries; the pinned count has no effect
// - joint array mmu: flush invalidates every entry and ignores the pointer
// - var/fixed mmu, software walk: flush hits variable array or one fixed set
// - var/fixed mmu, hardware walk: one flush invalidates both arrays
// - flush, probe and read trap as coprocessor unusable without cp0 access
// - release-6 cores with block or fixed-map mmu raise reserved instruction
// - flush support is reported by invalidate field; entry-invalid flag exists
// - probe and read decoded from major/minor groups and sub-opcode bits
// - probe loads pointer with position of matching entry
// - probe miss sets the pointer's most significant bit
// - release-3 may flag multiple matches on probe as machine check
// - read copies pointed entry into tag, page and page-size registers
// - read of invalidated entry returns zeros, invalid flag set, smallest page, unless invalidate field is none (stored data, flag clear)
// - read zeroes vpn and frame bits covered by the stored mask
// - read fills both page global flags from the single stored global bit
// - range flush selects by pointer, or takes all entries for joint or hardware-walk mmu, ignoring virtual tag contents
`timescale 1ns/1ps
`default_nettype none
`include "tlb_maint_defines.vh"

module tlb_maintenance_ops #(
    parameter ENTRIES    = 16,  // total entries
    parameter VAR_ENT    = 8,   // variable-array entries
    parameter LOG2_WAYS  = 2,   // log2 of fixed-array ways per set
    parameter IDX_W      = 4,   // entry index width
    parameter PTR_W      = 32,  // entry pointer register width
    parameter VPN_W      = 19,  // virtual page pair width
    parameter ADDRESS_SPACE_ID_W     = 8,   // address-space id width
    parameter MASK_W     = 16,  // page mask width
    parameter PFN_W      = 24,  // physical frame width
    parameter MASK_ZERO  = 1    // zero masked vpn/frame bits on read
) (
    input  wire                clk,            // core clock
    input  wire                rst,            // synchronous reset, active high
    input  wire [31:0]         instr,          // instruction from pipeline
    input  wire                instr_vld,      // instruction valid
    input  wire                cp0_usable,     // coprocessor 0 access enabled
    input  wire                rel6,           // core is release 6
    input  wire                rel3,           // core is release 3 or later
    input  wire [2:0]          mmu_type_field, // mmu type
    input  wire [1:0]          invalidate_support_field, // invalidate support
    input  wire [PTR_W-1:0]    entry_ptr_in,   // current entry pointer
    input  wire [VPN_W-1:0]    vtag_vpn_in,    // current virtual_page_pair
    input  wire [ADDRESS_SPACE_ID_W-1:0]   vtag_address_space_id_in,   // current address_space_id
    input  wire                wr_en,          // entry write from write path
    input  wire [IDX_W-1:0]    wr_index,       // entry to write
    input  wire                wr_inval,       // write marks entry invalid
    input  wire [VPN_W-1:0]    wr_vpn,         // vpn to store
    input  wire [ADDRESS_SPACE_ID_W-1:0]   wr_address_space_id,        // address_space_id to store
    input  wire [MASK_W-1:0]   wr_mask,        // page mask to store
    input  wire                wr_global,      // anded global bit
    input  wire [PFN_W+4:0]    wr_even,        // even frame, c3, d, v
    input  wire [PFN_W+4:0]    wr_odd,         // odd frame, c3, d, v
    output reg  [PTR_W-1:0]    entry_ptr_out,  // new pointer value
    output reg                 entry_ptr_load, // pointer update pulse
    output reg  [VPN_W-1:0]    vtag_vpn_out,   // read virtual_page_pair
    output reg  [ADDRESS_SPACE_ID_W-1:0]   vtag_address_space_id_out,  // read address_space_id
    output reg                 entry_invalid_flag, // read entry_invalid_flag
    output reg  [PFN_W+5:0]    even_page_reg,  // read even page
    output reg  [PFN_W+5:0]    odd_page_reg,   // read odd page
    output reg  [MASK_W-1:0]   page_size_reg,  // read page mask
    output reg                 read_load,      // staging update pulse
    output reg                 flush_done,     // flush complete pulse
    output reg                 exc_cop_unusable, // coprocessor unusable pulse
    output reg                 exc_reserved,   // reserved instruction pulse
    output reg                 exc_machine_check, // multiple-match pulse
    output reg                 flush_present   // flush supported
);

    // ------------------------------------------------------------------------
    // entry storage
    // ------------------------------------------------------------------------
    reg [VPN_W-1:0]  t_vpn   [0:ENTRIES-1];
    reg [ADDRESS_SPACE_ID_W-1:0] t_address_space_id  [0:ENTRIES-1];
    reg [MASK_W-1:0] t_mask  [0:ENTRIES-1];
    reg              t_g     [0:ENTRIES-1];
    reg [PFN_W+4:0]  t_even  [0:ENTRIES-1];
    reg [PFN_W+4:0]  t_odd   [0:ENTRIES-1];
    reg              t_inval [0:ENTRIES-1];

    // ------------------------------------------------------------------------
    // decode and gating
    // ------------------------------------------------------------------------
    wire is_flush;
    wire is_probe;
    wire is_read;

    tlb_op_decoder u_dec (
        .instr     (instr),
        .instr_vld (instr_vld),
        .is_flush  (is_flush),
        .is_probe  (is_probe),
        .is_read   (is_read)
    );

    wire any_op    = is_flush | is_probe | is_read;
    wire ri_mmu    = rel6 & ((mmu_type_field == `MMU_BLOCK) |
                             (mmu_type_field == `MMU_FIXED_MAP));
    wire no_flush  = is_flush & (invalidate_support_field == `INV_NONE);
    wire cpu_trap  = any_op & ~cp0_usable;
    wire ri_trap   = any_op & cp0_usable & (ri_mmu | no_flush);
    wire go        = cp0_usable & ~ri_mmu & ~no_flush;
    wire do_flush  = is_flush & go;
    wire do_probe  = is_probe & go;
    wire do_read   = is_read & go;

    wire [IDX_W-1:0] ptr_idx = entry_ptr_in[IDX_W-1:0];
    wire [IDX_W-1:0] ptr_rel = ptr_idx - VAR_ENT[IDX_W-1:0];
    wire             ptr_var = ptr_idx < VAR_ENT[IDX_W-1:0];
    wire             all_ent = (mmu_type_field == `MMU_JOINT) |
                               ((mmu_type_field == `MMU_VAR_FIXED) &
                                (invalidate_support_field == `INV_HW_WALK));
    wire             sw_walk = (mmu_type_field == `MMU_VAR_FIXED) &
                               (invalidate_support_field == `INV_SW_WALK);

    // ------------------------------------------------------------------------
    // per-entry range and match
    // ------------------------------------------------------------------------
    wire [ENTRIES-1:0] in_range;
    wire [ENTRIES-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi = gi + 1) begin : g_ent
            wire [VPN_W-1:0] cmp_mask;
            assign cmp_mask = ~{{(VPN_W-MASK_W){1'b0}}, t_mask[gi]};
            if (gi < VAR_ENT) begin : g_var
                // pointer or all_ent picks the range; tag contents never looked at
                assign in_range[gi] = all_ent | (sw_walk & ptr_var);
            end else begin : g_fix
                localparam [IDX_W-1:0] REL = gi - VAR_ENT;
                assign in_range[gi] = all_ent | (sw_walk & ~ptr_var &
                                      ((REL >> LOG2_WAYS) == (ptr_rel >> LOG2_WAYS)));
            end
            assign hit[gi] = ~t_inval[gi] &
                             (((t_vpn[gi] ^ vtag_vpn_in) & cmp_mask) == {VPN_W{1'b0}}) &
                             (t_g[gi] | (t_address_space_id[gi] == vtag_address_space_id_in));
        end
    endgenerate

    // ------------------------------------------------------------------------
    // probe priority encode
    // ------------------------------------------------------------------------
    reg [IDX_W-1:0] hit_idx;
    reg             hit_any;
    reg             hit_multi;
    integer         k;

    always @* begin
        hit_idx   = {IDX_W{1'b0}};
        hit_any   = 1'b0;
        hit_multi = 1'b0;
        for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
            if (hit[k]) begin
                if (hit_any) begin
                    hit_multi = 1'b1;
                end
                hit_any = 1'b1;
                hit_idx = k[IDX_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // read data formation
    // ------------------------------------------------------------------------
    wire [MASK_W-1:0] r_mask = t_mask[ptr_idx];
    wire [VPN_W-1:0]  r_vmk  = MASK_ZERO ? ~{{(VPN_W-MASK_W){1'b0}}, r_mask} : {VPN_W{1'b1}};
    wire [PFN_W-1:0]  r_pmk  = MASK_ZERO ? ~{{(PFN_W-MASK_W){1'b0}}, r_mask} : {PFN_W{1'b1}};
    wire [PFN_W+4:0]  r_even = t_even[ptr_idx];
    wire [PFN_W+4:0]  r_odd  = t_odd[ptr_idx];
    wire              r_inv  = (invalidate_support_field != `INV_NONE) & t_inval[ptr_idx];

    // ------------------------------------------------------------------------
    // entry update
    // ------------------------------------------------------------------------
    integer e;

    always @(posedge clk) begin
        if (rst) begin
            for (e = 0; e < ENTRIES; e = e + 1) begin
                t_inval[e] <= 1'b1;
                t_vpn[e]   <= {VPN_W{1'b0}};
                t_address_space_id[e]  <= {ADDRESS_SPACE_ID_W{1'b0}};
                t_mask[e]  <= {MASK_W{1'b0}};
                t_g[e]     <= 1'b0;
                t_even[e]  <= {(PFN_W+5){1'b0}};
                t_odd[e]   <= {(PFN_W+5){1'b0}};
            end
        end else begin
            if (wr_en) begin
                t_inval[wr_index] <= wr_inval;
                t_vpn[wr_index]   <= wr_vpn;
                t_address_space_id[wr_index]  <= wr_address_space_id;
                t_mask[wr_index]  <= wr_mask;
                t_g[wr_index]     <= wr_global;
                t_even[wr_index]  <= wr_even;
                t_odd[wr_index]   <= wr_odd;
            end
            // flush loop placed last so it wins over a same-cycle write
            for (e = 0; e < ENTRIES; e = e + 1) begin
                if (do_flush & in_range[e]) begin
                    t_inval[e] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // result and exception registers
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            entry_ptr_out      <= {PTR_W{1'b0}};
            entry_ptr_load     <= 1'b0;
            vtag_vpn_out       <= {VPN_W{1'b0}};
            vtag_address_space_id_out      <= {ADDRESS_SPACE_ID_W{1'b0}};
            entry_invalid_flag <= 1'b0;
            even_page_reg      <= {(PFN_W+6){1'b0}};
            odd_page_reg       <= {(PFN_W+6){1'b0}};
            page_size_reg      <= {MASK_W{`SMALLEST_PAGE_MASK}};
            read_load          <= 1'b0;
            flush_done         <= 1'b0;
            exc_cop_unusable   <= 1'b0;
            exc_reserved       <= 1'b0;
            exc_machine_check  <= 1'b0;
            flush_present      <= 1'b0;
        end else begin
            flush_present     <= invalidate_support_field != `INV_NONE;
            exc_cop_unusable  <= cpu_trap;
            exc_reserved      <= ri_trap;
            flush_done        <= do_flush;
            exc_machine_check <= do_probe & rel3 & hit_multi;
            entry_ptr_load    <= do_probe & ~(rel3 & hit_multi);
            read_load         <= do_read;
            if (do_probe) begin
                if (hit_any) begin
                    entry_ptr_out <= {{(PTR_W-IDX_W){1'b0}}, hit_idx};
                end else begin
                    entry_ptr_out <= {1'b1, {(PTR_W-1){1'b0}}};
                end
            end
            if (do_read) begin
                if (r_inv) begin
                    vtag_vpn_out       <= {VPN_W{1'b0}};
                    vtag_address_space_id_out      <= {ADDRESS_SPACE_ID_W{1'b0}};
                    entry_invalid_flag <= 1'b1;
                    even_page_reg      <= {(PFN_W+6){1'b0}};
                    odd_page_reg       <= {(PFN_W+6){1'b0}};
                    page_size_reg      <= {MASK_W{`SMALLEST_PAGE_MASK}};
                end else begin
                    vtag_vpn_out       <= t_vpn[ptr_idx] & r_vmk;
                    vtag_address_space_id_out      <= t_address_space_id[ptr_idx];
                    entry_invalid_flag <= 1'b0;
                    even_page_reg      <= {r_even[PFN_W+4:5] & r_pmk, r_even[4:0],
                                           t_g[ptr_idx]};
                    odd_page_reg       <= {r_odd[PFN_W+4:5] & r_pmk, r_odd[4:0],
                                           t_g[ptr_idx]};
                    page_size_reg      <= r_mask;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* tb/tlb_maint_checker.sv */
// assertion checker for the translation-buffer maintenance block
`timescale 1ns/1ps
`default_nettype none
module tlb_maint_checker #(
    parameter PTR_W  = 32,
    parameter PFN_W  = 24,
    parameter MASK_W = 16
) (
    input wire logic              clk,               // core clock
    input wire logic              rst,               // sync reset
    input wire logic [31:0]       instr,             // instruction word
    input wire logic              instr_vld,         // word valid
    input wire logic              cp0_usable,        // cp0 access
    input wire logic              rel6,              // release 6
    input wire logic              rel3,              // release 3+
    input wire logic [2:0]        mmu_type_field,    // mmu type
    input wire logic [1:0]        invalidate_support_field, // inval support
    input wire logic [PTR_W-1:0]  entry_ptr_out,     // probe result
    input wire logic              entry_ptr_load,    // probe pulse
    input wire logic              entry_invalid_flag, // read invalid flag
    input wire logic [PFN_W+5:0]  even_page_reg,     // read even page
    input wire logic [PFN_W+5:0]  odd_page_reg,      // read odd page
    input wire logic [MASK_W-1:0] page_size_reg,     // read mask
    input wire logic              read_load,         // read pulse
    input wire logic              flush_done,        // flush pulse
    input wire logic              exc_cop_unusable,  // cp0 trap
    input wire logic              exc_reserved,      // reserved trap
    input wire logic              exc_machine_check, // multi-hit trap
    input wire logic              flush_present      // flush supported
);
    wire logic [9:0] sub  = instr[15:6];
    wire logic       take = instr_vld && instr[31:16] == 16'h0000 && instr[5:0] == 6'h3c;
    wire logic       is_op = take && (sub == 10'h00d || sub == 10'h04d || sub == 10'h14d);
    wire logic       ok = cp0_usable && !(rel6 && (mmu_type_field == 3'h2 || mmu_type_field == 3'h3));
    wire logic       quiet = !flush_done && !read_load && !entry_ptr_load;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence probe_req; is_op && ok && sub == 10'h00d; endsequence
    sequence read_req; is_op && ok && sub == 10'h04d; endsequence
    sequence flush_req; is_op && ok && sub == 10'h14d && invalidate_support_field != 2'h0; endsequence
    cop_unusable_a: assert property (is_op && !cp0_usable |=> exc_cop_unusable && !exc_reserved && quiet)
        else $error("cp0 trap missing or op executed");
    reserved_op_a: assert property (is_op && cp0_usable && !ok |=> exc_reserved && !exc_cop_unusable && quiet)
        else $error("reserved trap missing or op executed");
    flush_done_a: assert property (flush_req |=> flush_done && !exc_reserved)
        else $error("flush not executed");
    probe_answer_a: assert property (probe_req |=> entry_ptr_load ^ exc_machine_check)
        else $error("probe gave no single answer");
    miss_pointer_a: assert property (entry_ptr_load && entry_ptr_out[PTR_W-1] |-> entry_ptr_out[PTR_W-2:0] == '0)
        else $error("miss pointer has stray bits");
    multi_hit_a: assert property (exc_machine_check |-> $past(rel3) && !entry_ptr_load)
        else $error("machine check without release 3");
    read_answer_a: assert property (read_req |=> read_load)
        else $error("read not executed");
    invalid_read_a: assert property (read_load && entry_invalid_flag |->
        even_page_reg == '0 && odd_page_reg == '0 && page_size_reg == '0)
        else $error("invalid entry read not cleared");
    global_copy_a: assert property (read_load |-> even_page_reg[0] == odd_page_reg[0])
        else $error("page global flags differ");
    flush_present_a: assert property (1'b1 |=> flush_present == ($past(invalidate_support_field) != 2'h0))
        else $error("flush support flag wrong");
    stray_pulse_a: assert property ((flush_done || read_load || entry_ptr_load) |-> $past(instr_vld))
        else $error("result without request");
endmodule
bind tlb_maintenance_ops tlb_maint_checker #(.PTR_W(PTR_W), .PFN_W(PFN_W), .MASK_W(MASK_W)) tlb_maint_checker_inst (
    .clk(clk), .rst(rst), .instr(instr), .instr_vld(instr_vld), .cp0_usable(cp0_usable), .rel6(rel6), .rel3(rel3),
    .mmu_type_field(mmu_type_field), .invalidate_support_field(invalidate_support_field),
    .entry_ptr_out(entry_ptr_out), .entry_ptr_load(entry_ptr_load), .entry_invalid_flag(entry_invalid_flag),
    .even_page_reg(even_page_reg), .odd_page_reg(odd_page_reg), .page_size_reg(page_size_reg),
    .read_load(read_load), .flush_done(flush_done), .exc_cop_unusable(exc_cop_unusable),
    .exc_reserved(exc_reserved), .exc_machine_check(exc_machine_check), .flush_present(flush_present));
`default_nettype wire

/* tb/tlb_pipe_model.sv */
// instruction pipeline model issuing maintenance words
`timescale 1ns/1ps
`default_nettype none
module tlb_pipe_model (
    input  wire logic        go,        // issue request
    input  wire logic [9:0]  sub,       // operation sub-opcode
    output wire logic [31:0] instr,     // instruction word
    output wire logic        instr_vld  // word valid
);
    wire logic [31:0] word = {6'h00, 10'h000, sub, 6'h3c};
    // idle bus shows the inverted word so nothing stale decodes
    assign instr     = go ? word : ~word;
    assign instr_vld = go;
endmodule
`default_nettype wire

/* tb/tlb_maintenance_ops_test.sv */
// self-checking bench for the translation-buffer maintenance block
`timescale 1ns/1ps
`default_nettype none
module tlb_maintenance_ops_test;
    localparam [9:0] PRB = 10'h00d, RD = 10'h04d, FL = 10'h14d;
    logic        clk, rst, go, instr_vld, cp0_usable, rel6, rel3, wr_en, wr_inval, wr_global;
    logic        entry_ptr_load, entry_invalid_flag, read_load, flush_done, flush_present;
    logic        exc_cop_unusable, exc_reserved, exc_machine_check;
    logic [9:0]  sub;
    logic [31:0] instr, ptr, entry_ptr_out;
    logic [18:0] vpn, wr_vpn, vtag_vpn_out;
    logic [7:0]  address_space_id, wr_address_space_id, vtag_address_space_id_out;
    logic [15:0] wr_mask, page_size_reg;
    logic [28:0] wr_even, wr_odd;
    logic [29:0] even_page_reg, odd_page_reg;
    logic [3:0]  wr_index;
    logic [2:0]  mmu;
    logic [1:0]  ie;
    int          fail_count, n_tests, cyc;

    tlb_pipe_model tlb_pipe_model_inst (.go(go), .sub(sub), .instr(instr), .instr_vld(instr_vld));
    tlb_maintenance_ops tlb_maintenance_ops_inst (
        .clk(clk), .rst(rst), .instr(instr), .instr_vld(instr_vld), .cp0_usable(cp0_usable), .rel6(rel6),
        .rel3(rel3), .mmu_type_field(mmu), .invalidate_support_field(ie), .entry_ptr_in(ptr),
        .vtag_vpn_in(vpn), .vtag_address_space_id_in(address_space_id), .wr_en(wr_en), .wr_index(wr_index), .wr_inval(wr_inval),
        .wr_vpn(wr_vpn), .wr_address_space_id(wr_address_space_id), .wr_mask(wr_mask), .wr_global(wr_global), .wr_even(wr_even),
        .wr_odd(wr_odd), .entry_ptr_out(entry_ptr_out), .entry_ptr_load(entry_ptr_load),
        .vtag_vpn_out(vtag_vpn_out), .vtag_address_space_id_out(vtag_address_space_id_out), .entry_invalid_flag(entry_invalid_flag),
        .even_page_reg(even_page_reg), .odd_page_reg(odd_page_reg), .page_size_reg(page_size_reg),
        .read_load(read_load), .flush_done(flush_done), .exc_cop_unusable(exc_cop_unusable),
        .exc_reserved(exc_reserved), .exc_machine_check(exc_machine_check), .flush_present(flush_present));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    // wide enough for a load pulse, the full pointer and a trap bit together
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one word taken, results left on the outputs for one cycle
    task automatic op(input logic [9:0] s);
        @(posedge clk); #1;
        go = 1'b1; sub = s;
        @(posedge clk); #1;
        go = 1'b0;
    endtask
    task automatic wr(input logic [3:0] i, input logic [18:0] v, input logic [7:0] a, input logic [15:0] m,
                      input logic g, input logic [28:0] e, input logic [28:0] o);
        @(posedge clk); #1;
        wr_en = 1'b1; wr_index = i; wr_vpn = v; wr_address_space_id = a; wr_mask = m; wr_global = g; wr_even = e; wr_odd = o;
        @(posedge clk); #1;
        wr_en = 1'b0;
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_read;
        wr(4'h3, 19'h7ffff, 8'h5a, 16'h0003, 1'b1, {24'hffffff, 5'h1b}, {24'h123457, 5'h05});
        ptr = 32'h3;
        op(RD);
        chk(read_load, 1'b1);
        chk({entry_invalid_flag, vtag_address_space_id_out, page_size_reg}, {1'b0, 8'h5a, 16'h0003});
        chk(vtag_vpn_out, 19'h7fffc);
        chk(even_page_reg, {24'hfffffc, 5'h1b, 1'b1});
        chk(odd_page_reg, {24'h123454, 5'h05, 1'b1});
    endtask
    task automatic t_probe;
        vpn = 19'h7fffc; address_space_id = 8'h5a;
        op(PRB);
        chk({entry_ptr_load, entry_ptr_out}, {1'b1, 32'h3});
        vpn = 19'h00001;
        op(PRB);
        chk({entry_ptr_load, entry_ptr_out}, {1'b1, 32'h80000000});
        wr(4'h5, 19'h7fffc, 8'h5a, 16'h0000, 1'b0, 29'h0, 29'h0);
        vpn = 19'h7fffc;
        op(PRB);
        chk({entry_ptr_load, entry_ptr_out, exc_machine_check}, {1'b1, 32'h3, 1'b0});
        rel3 = 1'b1;
        op(PRB);
        chk({entry_ptr_load, exc_machine_check}, 2'b01);
        rel3 = 1'b0;
    endtask
    // refill all entries as global, flush, then read back every entry
    task automatic t_flush(input logic [2:0] t, input logic [1:0] e, input logic [31:0] p, input logic [15:0] x);
        for (int i = 0; i < 16; i++) begin
            wr(4'(i), 19'h100 | 19'(i), 8'h20 | 8'(i), 16'h0000, 1'b1, 29'h1f, 29'h1f);
        end
        mmu = t; ie = e; ptr = p; address_space_id = 8'hff; vpn = 19'h101;
        op(FL);
        chk(flush_done, 1'b1);
        for (int i = 0; i < 16; i++) begin
            ptr = 32'(i);
            op(RD);
            chk({entry_invalid_flag, vtag_vpn_out}, {x[i], x[i] ? 19'h0 : 19'h100 | 19'(i)});
        end
        mmu = 3'h4; ie = 2'h2;
    endtask
    task automatic t_exc;
        logic [9:0] ops [3];
        ops = '{PRB, RD, FL};
        for (int i = 0; i < 3; i++) begin
            cp0_usable = 1'b0; rel6 = 1'b1; mmu = 3'h2;
            op(ops[i]);
            chk({exc_cop_unusable, exc_reserved, flush_done, read_load, entry_ptr_load}, 5'h10);
            cp0_usable = 1'b1; mmu = 3'h2 + 3'(i & 1);
            op(ops[i]);
            chk({exc_cop_unusable, exc_reserved, flush_done, read_load, entry_ptr_load}, 5'h08);
        end
        rel6 = 1'b0; mmu = 3'h4; ie = 2'h0;
        op(10'h02d);
        chk({exc_cop_unusable, exc_reserved, flush_done, read_load, entry_ptr_load}, 5'h00);
        op(FL);
        chk({flush_present, exc_reserved, flush_done}, 3'b010);
        ie = 2'h2;
        op(PRB);
        chk(flush_present, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // clock, timeout, main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 5000) begin
                fail_count++;
                finish_test();
            end
        end
    end
    initial begin
        fail_count = 0; n_tests = 0;
        rst = 1'b1; go = 1'b0; sub = 10'h0; cp0_usable = 1'b1; rel6 = 1'b0; rel3 = 1'b0;
        mmu = 3'h4; ie = 2'h2; ptr = 32'h0; vpn = 19'h0; address_space_id = 8'h0;
        wr_en = 1'b0; wr_index = 4'h0; wr_inval = 1'b0; wr_vpn = 19'h0; wr_address_space_id = 8'h0;
        wr_mask = 16'h0; wr_global = 1'b0; wr_even = 29'h0; wr_odd = 29'h0;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_read();
        t_probe();
        t_flush(3'h4, 2'h2, 32'h9, 16'h0f00);
        t_flush(3'h4, 2'h2, 32'hd, 16'hf000);
        t_flush(3'h4, 2'h2, 32'h2, 16'h00ff);
        t_flush(3'h1, 2'h1, 32'h9, 16'hffff);
        t_flush(3'h4, 2'h3, 32'h9, 16'hffff);
        t_exc();
        finish_test();
    end
endmodule
`default_nettype wire
